// >>> core/epc_counter.sv
`timescale 1ns/1ps
`default_nettype none
`include "epc_consts.svh"

module epc_counter
  import epc_pkg::*;
(
  // clock and reset
  input  wire logic                    sys_clk_in,
  input  wire logic                    reset_in,
  // register port
  input  wire logic [`EPC_ADDR_W-1:0]  reg_addr_in,
  input  wire logic [31:0]             reg_wdata_in,
  input  wire logic                    reg_wr_in,
  input  wire logic                    reg_rd_in,
  output logic      [31:0]             reg_rdata_out,
  // input terminals, index 4 is high_speed_pulse_input
  input  wire logic [`EPC_NUM_X-1:0]   x_term_in,
  // retention store
  input  wire logic                    retain_load_in,
  input  wire logic [`EPC_CNT_W-1:0]   retain_value_in,
  output logic      [`EPC_CNT_W-1:0]   retain_count_out,
  // digital outputs and interrupt
  output logic      [`EPC_NUM_DO-1:0]  do_term_out,
  output logic                         irq_out
);

  epc_count_t                   count_q;
  epc_count_t                   set_count_limit_q;
  epc_count_t                   designated_count_threshold_q;
  epc_func_t                    x_func_q [`EPC_NUM_X];
  epc_func_t                    do_func_q [`EPC_NUM_DO];
  epc_status_t                  status_q;
  epc_status_t                  mask_q;
  epc_status_t                  status_set;
  logic [`EPC_NUM_X-1:0]        x_prev_q;
  logic [`EPC_NUM_X-1:0]        x_hit;
  logic [`EPC_NUM_DO-1:0]       do_d;
  logic [`EPC_FN_W*`EPC_NUM_X-1:0]  x_func_flat;
  logic [`EPC_FN_W*`EPC_NUM_DO-1:0] do_func_flat;
  logic                         set_flag_q;
  logic                         desig_flag_q;
  logic                         pulse;
  logic                         halted;
  logic                         clear_wr;
  logic                         wr_limit;
  logic                         wr_desig;
  logic                         wr_status;
  logic                         wr_mask;
  logic                         wr_xfunc;
  logic                         wr_dofunc;
  logic [31:0]                  rdata_d;

  // write decode
  assign clear_wr  = reg_wr_in && reg_addr_in == `EPC_REG_CTRL
                     && reg_wdata_in[`EPC_CTRL_CLEAR];
  assign wr_limit  = reg_wr_in && reg_addr_in == `EPC_REG_LIMIT;
  assign wr_desig  = reg_wr_in && reg_addr_in == `EPC_REG_DESIG;
  assign wr_status = reg_wr_in && reg_addr_in == `EPC_REG_STATUS;
  assign wr_mask   = reg_wr_in && reg_addr_in == `EPC_REG_MASK;
  assign wr_xfunc  = reg_wr_in && reg_addr_in == `EPC_REG_XFUNC;
  assign wr_dofunc = reg_wr_in && reg_addr_in == `EPC_REG_DOFUNC;

  // per-terminal edge detect and function match
  genvar gi;
  generate
    for (gi = 0; gi < `EPC_NUM_X; gi++)
    begin : g_x
      assign x_hit[gi] = x_term_in[gi] && !x_prev_q[gi]
                         && x_func_q[gi] == `EPC_FN_COUNT_IN;
      assign x_func_flat[gi*`EPC_FN_W +: `EPC_FN_W] = x_func_q[gi];

      // terminal function registers
      always_ff @(posedge sys_clk_in)
      begin
        if (reset_in)
          x_func_q[gi] <= `EPC_RST_FN;
        else if (wr_xfunc)
          x_func_q[gi] <= reg_wdata_in[gi*`EPC_FN_W +: `EPC_FN_W];
      end
    end

    for (gi = 0; gi < `EPC_NUM_DO; gi++)
    begin : g_do
      assign do_d[gi] = (do_func_q[gi] == `EPC_FN_SET_HIT && set_flag_q)
                        || (do_func_q[gi] == `EPC_FN_DESIG_HIT && desig_flag_q);
      assign do_func_flat[gi*`EPC_FN_W +: `EPC_FN_W] = do_func_q[gi];

      // output function registers
      always_ff @(posedge sys_clk_in)
      begin
        if (reset_in)
          do_func_q[gi] <= `EPC_RST_FN;
        else if (wr_dofunc)
          do_func_q[gi] <= reg_wdata_in[gi*`EPC_FN_W +: `EPC_FN_W];
      end
    end
  endgenerate

  // previous terminal levels
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
      x_prev_q <= '0;
    else
      x_prev_q <= x_term_in;
  end

  assign pulse  = |x_hit;
  assign halted = count_q >= set_count_limit_q;

  // running count, no run/stop qualifier
  // counts in run and stop
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
      count_q <= `EPC_ZERO32;
    else if (clear_wr)
      count_q <= `EPC_ZERO32;
    else if (retain_load_in)
      count_q <= retain_value_in;
    else if (pulse && !halted)
      count_q <= count_q + `EPC_CNT_W'(1);
  end

  // threshold registers
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      set_count_limit_q            <= `EPC_RST_LIMIT;
      designated_count_threshold_q <= `EPC_RST_DESIG;
    end
    else
    begin
      if (wr_limit)
        set_count_limit_q <= reg_wdata_in;
      if (wr_desig)
        designated_count_threshold_q <= reg_wdata_in;
    end
  end

  // threshold flags, fall when count drops below
  // level flags from comparison
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      set_flag_q   <= 1'b0;
      desig_flag_q <= 1'b0;
    end
    else
    begin
      set_flag_q   <= count_q >= set_count_limit_q;
      desig_flag_q <= count_q >= designated_count_threshold_q;
    end
  end

  // event sources: flag rises and dropped pulses
  always_comb
  begin
    status_set = '0;
    status_set[`EPC_ST_DESIG] = !desig_flag_q
                                && count_q >= designated_count_threshold_q;
    status_set[`EPC_ST_SET]   = !set_flag_q && halted;
    status_set[`EPC_ST_DROP]  = pulse && halted;
  end

  // sticky status, set wins over write-one-clear
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
      status_q <= '0;
    else if (wr_status)
      status_q <= (status_q & ~reg_wdata_in[`EPC_ST_W-1:0]) | status_set;
    else
      status_q <= status_q | status_set;
  end

  // interrupt mask
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
      mask_q <= '0;
    else if (wr_mask)
      mask_q <= reg_wdata_in[`EPC_ST_W-1:0];
  end

  // registered outputs
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      do_term_out      <= '0;
      irq_out          <= 1'b0;
      retain_count_out <= `EPC_ZERO32;
    end
    else
    begin
      do_term_out      <= do_d;
      irq_out          <= |(status_q & mask_q);
      retain_count_out <= count_q;
    end
  end

  // read mux, unmapped reads zero
  always_comb
  begin
    rdata_d = '0;
    unique case (reg_addr_in)
      `EPC_REG_LIMIT:  rdata_d = set_count_limit_q;
      `EPC_REG_DESIG:  rdata_d = designated_count_threshold_q;
      `EPC_REG_COUNT:  rdata_d = count_q;
      `EPC_REG_STATUS: rdata_d[`EPC_ST_W-1:0] = status_q;
      `EPC_REG_MASK:   rdata_d[`EPC_ST_W-1:0] = mask_q;
      `EPC_REG_XFUNC:  rdata_d[`EPC_FN_W*`EPC_NUM_X-1:0] = x_func_flat;
      `EPC_REG_DOFUNC: rdata_d[`EPC_FN_W*`EPC_NUM_DO-1:0] = do_func_flat;
      `EPC_REG_FLAGS:  rdata_d[`EPC_ST_SET:`EPC_ST_DESIG] = {set_flag_q, desig_flag_q};
      default:         rdata_d = '0;
    endcase
  end

  // read data one cycle after strobe
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
      reg_rdata_out <= '0;
    else if (reg_rd_in)
      reg_rdata_out <= rdata_d;
    else
      reg_rdata_out <= '0;
  end

  // checks on count, flag, output and retention behaviour
  // accepted pulse adds one
  AST_COUNT_STEP: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    pulse && !halted && !clear_wr && !retain_load_in
    |=> count_q == $past(count_q) + `EPC_CNT_W'(1))
    else $error("count did not step on pulse");

  AST_HALT_HOLD: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    halted && !clear_wr && !retain_load_in |=> $stable(count_q))
    else $error("count moved after limit");

  AST_SET_FLAG: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    count_q == set_count_limit_q |=> set_flag_q)
    else $error("set flag missing at limit");

  AST_SET_DO: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    set_flag_q && do_func_q[0] == `EPC_FN_SET_HIT |=> do_term_out[0])
    else $error("code 8 output not on");

  AST_DESIG_DO: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    count_q == designated_count_threshold_q
    && do_func_q[1] == `EPC_FN_DESIG_HIT && !wr_dofunc
    |=> ##1 do_term_out[1])
    else $error("code 9 output not on");

  AST_DESIG_FALL: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    count_q < designated_count_threshold_q |=> !desig_flag_q)
    else $error("designated flag held below threshold");

  AST_RETAIN: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    retain_load_in && !clear_wr |=> count_q == $past(retain_value_in))
    else $error("retained count not restored");

  // counting never exceeds limit by stepping
  AST_NO_OVERRUN: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    !halted && !retain_load_in |=> count_q <= set_count_limit_q || $changed(set_count_limit_q))
    else $error("count stepped past limit");

  // dropped pulse sticks until cleared
  AST_DROP_STICKY: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    pulse && halted |=> status_q[`EPC_ST_DROP])
    else $error("dropped pulse event lost");

  // interrupt tracks unmasked status
  AST_IRQ: assert property (@(posedge sys_clk_in) disable iff (reset_in)
    |(status_q & mask_q) |=> irq_out)
    else $error("interrupt not raised");

endmodule
`default_nettype wire

// >>> core/epc_consts.svh
`ifndef EPC_CONSTS_SVH
`define EPC_CONSTS_SVH

// widths and channel counts
`define EPC_ADDR_W        8
`define EPC_CNT_W         32
`define EPC_FN_W          6
`define EPC_NUM_X         5
`define EPC_NUM_DO        3

// terminal function codes
`define EPC_FN_COUNT_IN   6'h19
`define EPC_FN_SET_HIT    6'h08
`define EPC_FN_DESIG_HIT  6'h09

// register byte offsets
`define EPC_REG_CTRL      8'h00
`define EPC_REG_LIMIT     8'h04
`define EPC_REG_DESIG     8'h08
`define EPC_REG_COUNT     8'h0C
`define EPC_REG_STATUS    8'h10
`define EPC_REG_MASK      8'h14
`define EPC_REG_XFUNC     8'h18
`define EPC_REG_DOFUNC    8'h1C
`define EPC_REG_FLAGS     8'h20

// control, status and flag bit positions
`define EPC_CTRL_CLEAR    0
`define EPC_ST_DESIG      0
`define EPC_ST_SET        1
`define EPC_ST_DROP       2
`define EPC_ST_W          3

// reset values
`define EPC_RST_LIMIT     32'h0000FFFF
`define EPC_RST_DESIG     32'h0000FFFF
`define EPC_RST_FN        6'h00
`define EPC_ZERO32        32'h00000000

`endif

// >>> core/epc_pkg.sv
package epc_pkg;
  `include "epc_consts.svh"

  // running count and thresholds
  typedef logic [`EPC_CNT_W-1:0] epc_count_t;
  // terminal function code
  typedef logic [`EPC_FN_W-1:0]  epc_func_t;
  // sticky event bits
  typedef logic [`EPC_ST_W-1:0]  epc_status_t;
endpackage

// >>> dv/epc_far_model.sv
`timescale 1ns/1ps
`default_nettype none

module epc_far_model (
  // clock
  input  wire logic        sys_clk_in,
  // pulse request
  input  wire logic        go_in,
  input  wire logic [2:0]  term_sel_in,
  input  wire logic [7:0]  pulse_num_in,
  input  wire logic [3:0]  gap_in,
  output logic      [4:0]  x_term_out,
  output logic             busy_out,
  // retention store
  input  wire logic        save_en_in,
  input  wire logic [31:0] retain_count_in,
  output logic      [31:0] retain_value_out
);
  logic [7:0] left_q = 8'h00;
  logic [3:0] wait_q = 4'h0;

  initial x_term_out = 5'h00;
  initial retain_value_out = 32'h00000000;

  // one-cycle high pulses, then gap_in extra low cycles
  // trains on whichever terminal term_sel_in picks
  always @(posedge sys_clk_in)
  begin
    if (go_in)
    begin
      left_q <= pulse_num_in;
      wait_q <= 4'h0;
    end
    else if (x_term_out != 5'h00)
      x_term_out <= 5'h00;
    else if (wait_q != 4'h0)
      wait_q <= wait_q - 4'h1;
    else if (left_q != 8'h00)
    begin
      x_term_out <= 5'h01 << term_sel_in;
      left_q     <= left_q - 8'h01;
      wait_q     <= gap_in;
    end
  end

  // busy until the last low phase is over
  assign busy_out = (left_q != 8'h00) || (x_term_out != 5'h00) || (wait_q != 4'h0);

  // store keeps last count while powered
  always @(posedge sys_clk_in)
  begin
    if (save_en_in)
      retain_value_out <= retain_count_in;
  end
endmodule

`default_nettype wire

// >>> dv/tb_epc_counter.sv
`timescale 1ns/1ps
`default_nettype none
`include "epc_consts.svh"

module tb_epc_counter
  import epc_pkg::*;
();
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        go = 1'b0;
  logic        ld = 1'b0;
  logic        save = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h00000000;
  logic [2:0]  tsel = 3'h4;
  logic [7:0]  num = 8'h00;
  logic [3:0]  gap = 4'h0;
  logic [31:0] rdata;
  logic [31:0] rcnt;
  logic [31:0] rval;
  logic [4:0]  xt;
  logic [2:0]  dout;
  logic        irq;
  logic        busy;
  int          miscompares = 0;
  int          check_count = 0;

  // clock
  always #50 clk = ~clk;

  epc_counter uut (.sys_clk_in(clk), .reset_in(rst), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .x_term_in(xt),
    .retain_load_in(ld), .retain_value_in(rval), .retain_count_out(rcnt),
    .do_term_out(dout), .irq_out(irq));

  epc_far_model far (.sys_clk_in(clk), .go_in(go), .term_sel_in(tsel), .pulse_num_in(num),
    .gap_in(gap), .x_term_out(xt), .busy_out(busy), .save_en_in(save),
    .retain_count_in(rcnt), .retain_value_out(rval));

  // compare and report
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // verdict and stop
  task automatic end_sim();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // register write
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // register read, data in the cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 check(rdata, exp);
  endtask

  // pulse train from the far side, bounded wait
  task automatic pulses(input logic [2:0] t, input logic [7:0] n, input logic [3:0] g);
    int i;
    @(posedge clk);
    tsel <= t;
    num  <= n;
    gap  <= g;
    go   <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    #1;
    for (i = 0; i < 400 && busy; i++)
    begin
      @(posedge clk);
      #1;
    end
    if (busy !== 1'b0)
    begin
      miscompares++;
      end_sim();
    end
    repeat (3) @(posedge clk);
    #1;
  endtask

  // main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rd_reg(`EPC_REG_LIMIT, `EPC_RST_LIMIT);
    rd_reg(`EPC_REG_DESIG, `EPC_RST_DESIG);
    wr_reg(8'h24, 32'hFFFFFFFF);
    rd_reg(8'h24, 32'h00000000);
    wr_reg(`EPC_REG_XFUNC, 32'h19000000);
    wr_reg(`EPC_REG_DOFUNC, 32'h00000248);
    wr_reg(`EPC_REG_LIMIT, 32'h00000005);
    wr_reg(`EPC_REG_DESIG, 32'h00000003);
    wr_reg(`EPC_REG_MASK, 32'h00000007);
    pulses(3'h0, 8'h02, 4'h2);
    rd_reg(`EPC_REG_COUNT, 32'h00000000);
    pulses(3'h4, 8'h02, 4'h0);
    rd_reg(`EPC_REG_COUNT, 32'h00000002);
    check({29'h0, dout}, 32'h00000000);
    pulses(3'h4, 8'h01, 4'h3);
    check({29'h0, dout}, 32'h00000002);
    check({31'h0, irq}, 32'h00000001);
    pulses(3'h4, 8'h02, 4'h0);
    rd_reg(`EPC_REG_COUNT, 32'h00000005);
    check({29'h0, dout}, 32'h00000003);
    pulses(3'h4, 8'h02, 4'h0);
    rd_reg(`EPC_REG_COUNT, 32'h00000005);
    rd_reg(`EPC_REG_STATUS, 32'h00000007);
    wr_reg(`EPC_REG_STATUS, 32'h00000007);
    rd_reg(`EPC_REG_STATUS, 32'h00000000);
    check({31'h0, irq}, 32'h00000000);
    rd_reg(`EPC_REG_FLAGS, 32'h00000003);
    wr_reg(`EPC_REG_CTRL, 32'h00000001);
    rd_reg(`EPC_REG_COUNT, 32'h00000000);
    repeat (2) @(posedge clk);
    #1 check({29'h0, dout}, 32'h00000000);
    wr_reg(`EPC_REG_MASK, 32'h00000000);
    pulses(3'h4, 8'h03, 4'h0);
    rd_reg(`EPC_REG_STATUS, 32'h00000001);
    check({31'h0, irq}, 32'h00000000);
    wr_reg(`EPC_REG_DESIG, 32'h00000004);
    rd_reg(`EPC_REG_FLAGS, 32'h00000000);
    wr_reg(`EPC_REG_MASK, 32'h00000001);
    repeat (2) @(posedge clk);
    #1 check({31'h0, irq}, 32'h00000001);
    @(posedge clk);
    save <= 1'b0;
    rst  <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    #1 check(rcnt, 32'h00000000);
    @(posedge clk);
    ld <= 1'b1;
    @(posedge clk);
    ld <= 1'b0;
    rd_reg(`EPC_REG_COUNT, 32'h00000003);
    check(rcnt, 32'h00000003);
    end_sim();
  end

  // hang guard
  initial
  begin
    #1000000;
    miscompares++;
    end_sim();
  end
endmodule

`default_nettype wire
